// ===== bench/pad_partner.sv
// far-side device model for one pad group, resolves the shared wire level
`timescale 1ns/100ps
`default_nettype none
module pad_partner #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] drv_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] ext_i,
  input  wire logic [W-1:0] ext_oe_i,
  output logic      [W-1:0] level_o
);
  // pads carry a board pull-up, so a released line reads high, never the last value
  assign level_o = (oe_i & drv_i) | (~oe_i & ext_oe_i & ext_i) | (~oe_i & ~ext_oe_i);
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the shared pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        ref_clk_i, resetn_i, ce_i, video_alt_i, storage_alt_i, nand_alt_i;
  logic        audio_alt_i, uart_alt_i, lcd_port_select_n_i, lcd_port_enable_read_i;
  logic        lcd_port_register_select_i, lcd_port_read_write_i, lcd_port_data_oe_i;
  logic        static_mem_select0_n_i, static_mem_select1_n_i, sdram_clock_out_i;
  logic        sdram_clock_enable_i, sdram_select_n_i, sdram_byte_mask1_i;
  logic        card_clock_i, card_command_i, card_command_oe_i, card_command_o;
  logic        audio_tx0_serial_data_i, audio_tx0_bit_clock_i, audio_tx0_word_select_i;
  logic        audio_tx0_master_clock_i, pcm_line_a_i, pcm_line_a_oe_i, pcm_frame_sync_i;
  logic        pcm_frame_sync_oe_i, pcm_data_clock_i, pcm_line_b_i, pcm_line_b_oe_i;
  logic        pcm_line_a_o, pcm_frame_sync_o, pcm_line_b_o;
  logic        uart_rts_n_i, uart_cts_n_o, spi_slave1_select_out_i, spi_slave2_select_out_i;
  logic [4:0]  mode_o;
  logic [15:0] lcd_port_data_i, lcd_port_data_o;
  logic [15:2] ext_mem_addr_i;
  logic [5:0]  general_io_i, general_io_oe_i, general_io_o;
  logic [7:0]  card_data_i, card_data_oe_i, card_data_o;
  logic [3:0]  flash_ready_busy_n_o;
  logic [19:0] video_pad_i, video_pad_o, video_pad_oe_o;
  logic [5:0]  storage_pad_i, storage_pad_o, storage_pad_oe_o;
  logic [3:0]  nand_pad_i, nand_pad_o, nand_pad_oe_o, audio_pad_i, audio_pad_o, audio_pad_oe_o;
  logic [1:0]  uart_pad_i, uart_pad_o, uart_pad_oe_o;
  logic [35:0] ext_v, ext_e;
  int          failures, tests_run, cycles;

  shared_pin_function_mux DUT (.*);

  // far-side devices, one per pad group; ext_v/ext_e slices are what they drive
  pad_partner #(.W(20)) vid_dev (.drv_i(video_pad_o), .oe_i(video_pad_oe_o),
    .ext_i(ext_v[19:0]), .ext_oe_i(ext_e[19:0]), .level_o(video_pad_i));
  pad_partner #(.W(6)) sto_dev (.drv_i(storage_pad_o), .oe_i(storage_pad_oe_o),
    .ext_i(ext_v[25:20]), .ext_oe_i(ext_e[25:20]), .level_o(storage_pad_i));
  pad_partner #(.W(4)) nand_dev (.drv_i(nand_pad_o), .oe_i(nand_pad_oe_o),
    .ext_i(ext_v[29:26]), .ext_oe_i(ext_e[29:26]), .level_o(nand_pad_i));
  pad_partner #(.W(4)) aud_dev (.drv_i(audio_pad_o), .oe_i(audio_pad_oe_o),
    .ext_i(ext_v[33:30]), .ext_oe_i(ext_e[33:30]), .level_o(audio_pad_i));
  pad_partner #(.W(2)) uart_dev (.drv_i(uart_pad_o), .oe_i(uart_pad_oe_o),
    .ext_i(ext_v[35:34]), .ext_oe_i(ext_e[35:34]), .level_o(uart_pad_i));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, well above the 54 cycles the scenarios need
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles >= 3000)
    begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // select takes one edge, pad drive one more; the third edge registers the pad return path
  task automatic settle();
    repeat (3) @(negedge ref_clk_i);
  endtask

  task automatic t_video_dflt();
    {lcd_port_read_write_i, lcd_port_register_select_i} = 2'b10;
    {lcd_port_enable_read_i, lcd_port_select_n_i} = 2'b10;
    lcd_port_data_i = 16'ha5c3;
    lcd_port_data_oe_i = 1'b1;
    settle();
    chk(video_pad_o, {4'ha, 16'ha5c3});
    chk(video_pad_oe_o, 20'hfffff);
    lcd_port_data_oe_i = 1'b0;
    ext_v[15:0] = 16'h5a3c;
    ext_e[15:0] = 16'hffff;
    settle();
    chk(video_pad_oe_o, 20'hf0000);
    chk(lcd_port_data_o, 16'h5a3c);
  endtask

  task automatic t_video_alt();
    video_alt_i = 1'b1;
    {sdram_byte_mask1_i, sdram_select_n_i, sdram_clock_enable_i} = 3'b010;
    {static_mem_select0_n_i, static_mem_select1_n_i, sdram_clock_out_i} = 3'b011;
    ext_mem_addr_i = 14'h2d4b;
    settle();
    chk(mode_o, 5'h01);
    chk(video_pad_o, {4'h4, 14'h2d4b, 2'b11});
    chk(video_pad_oe_o, 20'hfffff);
    chk(lcd_port_data_o, 16'h0000);
    video_alt_i = 1'b0;
    ext_e[19:0] = 20'h00000;
  endtask

  task automatic t_storage();
    general_io_i = 6'h2d;
    general_io_oe_i = 6'h0f;
    ext_v[25:20] = 6'h3c;
    ext_e[25:20] = 6'h30;
    settle();
    chk({storage_pad_oe_o, storage_pad_o}, {6'h0f, 6'h2d});
    chk(general_io_o, 6'h3d);
    storage_alt_i = 1'b1;
    {card_clock_i, card_command_i, card_command_oe_i} = 3'b100;
    card_data_i = 8'h96;
    card_data_oe_i = 8'h0f;
    ext_v[25:20] = 6'h00;
    ext_e[25:20] = 6'h02;
    settle();
    chk(mode_o, 5'h02);
    chk({storage_pad_oe_o, storage_pad_o}, {6'h3d, 6'h19});
    chk({card_command_o, card_data_o}, {1'b0, 8'hf6});
    chk(general_io_o, 6'h00);
    storage_alt_i = 1'b0;
  endtask

  task automatic t_nand();
    ext_v[29:26] = 4'ha;
    ext_e[29:26] = 4'hf;
    settle();
    chk(nand_pad_oe_o, 4'h0);
    chk(flash_ready_busy_n_o, 4'ha);
    nand_alt_i = 1'b1;
    card_data_i = 8'hc3;
    card_data_oe_i = 8'hf0;
    settle();
    chk(mode_o, 5'h04);
    chk({nand_pad_oe_o, nand_pad_o}, {4'hf, 4'hc});
    chk({flash_ready_busy_n_o, card_data_o}, {4'hf, 8'hcf});
    nand_alt_i = 1'b0;
  endtask

  task automatic t_audio();
    {audio_tx0_master_clock_i, audio_tx0_word_select_i} = 2'b10;
    {audio_tx0_bit_clock_i, audio_tx0_serial_data_i} = 2'b01;
    settle();
    chk({audio_pad_oe_o, audio_pad_o}, 8'hf9);
    chk({pcm_line_a_o, pcm_frame_sync_o, pcm_line_b_o}, 3'b000);
    audio_alt_i = 1'b1;
    {pcm_line_b_i, pcm_data_clock_i, pcm_frame_sync_i, pcm_line_a_i} = 4'b0110;
    {pcm_line_a_oe_i, pcm_frame_sync_oe_i, pcm_line_b_oe_i} = 3'b110;
    ext_v[33:30] = 4'h8;
    ext_e[33:30] = 4'h8;
    settle();
    chk(mode_o, 5'h08);
    chk(audio_pad_o, 4'h6);
    chk(audio_pad_oe_o, 4'h7);
    chk({pcm_line_a_o, pcm_frame_sync_o, pcm_line_b_o}, 3'b011);
    audio_alt_i = 1'b0;
  endtask

  task automatic t_uart();
    uart_rts_n_i = 1'b0;
    ext_v[35:34] = 2'b10;
    ext_e[35:34] = 2'b01;
    settle();
    chk({uart_pad_oe_o, uart_pad_o[1], uart_cts_n_o}, 4'b1000);
    uart_alt_i = 1'b1;
    {spi_slave2_select_out_i, spi_slave1_select_out_i} = 2'b01;
    settle();
    chk(mode_o, 5'h10);
    chk({uart_pad_oe_o, uart_pad_o, uart_cts_n_o}, 5'b11011);
    uart_alt_i = 1'b0;
  endtask

  // all selects flip while frozen, so mode_o keeps the uart setting of the last enabled edge
  task automatic t_indep();
    ce_i = 1'b0;
    {uart_alt_i, audio_alt_i, nand_alt_i, storage_alt_i, video_alt_i} = 5'h1f;
    settle();
    chk(mode_o, 5'h10);
    ce_i = 1'b1;
    settle();
    chk(mode_o, 5'h1f);
    storage_alt_i = 1'b0;
    settle();
    chk(mode_o, 5'h1d);
  endtask

  initial
  begin
    {resetn_i, ce_i, video_alt_i, storage_alt_i, nand_alt_i, audio_alt_i, uart_alt_i} = '0;
    {lcd_port_select_n_i, lcd_port_enable_read_i, lcd_port_register_select_i} = '0;
    {lcd_port_read_write_i, lcd_port_data_i, lcd_port_data_oe_i, ext_mem_addr_i} = '0;
    {static_mem_select0_n_i, static_mem_select1_n_i, sdram_clock_out_i} = '0;
    {sdram_clock_enable_i, sdram_select_n_i, sdram_byte_mask1_i} = '0;
    {general_io_i, general_io_oe_i, card_clock_i, card_command_i, card_command_oe_i} = '0;
    {card_data_i, card_data_oe_i, uart_rts_n_i, spi_slave1_select_out_i} = '0;
    {audio_tx0_serial_data_i, audio_tx0_bit_clock_i, audio_tx0_word_select_i} = '0;
    {audio_tx0_master_clock_i, pcm_line_a_i, pcm_line_a_oe_i, pcm_frame_sync_i} = '0;
    {pcm_frame_sync_oe_i, pcm_data_clock_i, pcm_line_b_i, pcm_line_b_oe_i} = '0;
    {spi_slave2_select_out_i, ext_v, ext_e, failures, tests_run, cycles} = '0;
    repeat (12) @(negedge ref_clk_i);
    chk({mode_o, video_pad_oe_o, card_data_o}, {5'h00, 20'h00000, 8'hff});
    chk({flash_ready_busy_n_o, uart_cts_n_o}, 5'h1f);
    resetn_i = 1'b1;
    ce_i = 1'b1;
    t_video_dflt();
    t_video_alt();
    t_storage();
    t_nand();
    t_audio();
    t_uart();
    t_indep();
    end_sim();
  end
endmodule
`default_nettype wire

// ===== hw/pad_group_mux.sv
// one registered pad group shared between two peripherals
`timescale 1ns/100ps
`default_nettype none
`include "pin_mux_map.svh"
module pad_group_mux #(
  parameter int         W         = 4,
  parameter logic [W-1:0] DFLT_IDLE = '0,
  parameter logic [W-1:0] ALT_IDLE  = '0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic         alt_i,
  input  wire logic [W-1:0] dflt_out_i,
  input  wire logic [W-1:0] dflt_oe_i,
  input  wire logic [W-1:0] alt_out_i,
  input  wire logic [W-1:0] alt_oe_i,
  input  wire logic [W-1:0] pad_i,
  output logic      [W-1:0] pad_o,
  output logic      [W-1:0] pad_oe_o,
  output logic      [W-1:0] dflt_in_o,
  output logic      [W-1:0] alt_in_o
);
  // pad drive: the selected owner alone drives the pins
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pad_o    <= {W{`PAD_RST}};
      pad_oe_o <= {W{`PAD_RST}};
    end
    else if (ce_i)
    begin
      pad_o    <= alt_i ? alt_out_i : dflt_out_i;
      pad_oe_o <= alt_i ? alt_oe_i : dflt_oe_i;
    end
  end

  // return path: the unrouted owner sees idle levels, not stray pin activity
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dflt_in_o <= DFLT_IDLE;
      alt_in_o  <= ALT_IDLE;
    end
    else if (ce_i)
    begin
      dflt_in_o <= alt_i ? DFLT_IDLE : pad_i;
      alt_in_o  <= alt_i ? pad_i : ALT_IDLE;
    end
  end
endmodule
`default_nettype wire

// ===== hw/pin_mux_map.svh
// constants for the shared pin multiplexer
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH
// pad group widths
`define VID_W        20
`define STO_W        6
`define NAND_W       4
`define AUD_W        4
`define UART_W       2
// video pad positions (bits 0..15 are the lcd data lines)
`define VID_DB0      0
`define VID_DB1      1
`define VID_DB2      2
`define VID_DB15     15
`define VID_CS       16
`define VID_ERD      17
`define VID_RS       18
`define VID_RW       19
// storage pad positions in alternate use
`define STO_CLK      0
`define STO_CMD      1
`define STO_DAT0     2
`define STO_DAT3     5
// uart pad positions
`define UART_CTS     0
`define UART_RTS     1
// audio pad positions in alternate use
`define AUD_LINE_A   0
`define AUD_SYNC     1
`define AUD_DCLK     2
`define AUD_LINE_B   3
// levels the unrouted peripheral sees
`define LCD_IDLE     20'h00000
`define GPIO_IDLE    6'h00
`define CARD_IDLE    6'h3f
`define RB_IDLE      4'hf
`define CARD_HI_IDLE 4'hf
`define I2S_IDLE     4'h0
`define PCM_IDLE     4'h0
`define MODEM_IDLE   2'h3
`define SPI_IDLE     2'h0
`define MEM_IDLE     20'h00000
// reset value of every pad drive and output enable flop
`define PAD_RST      1'b0
`endif

// ===== hw/pin_mux_pkg.sv
// types shared by the pin multiplexer
package pin_mux_pkg;
  // per-category routing, one-hot
  typedef enum logic [1:0]
  {
    MODE_DEFAULT = 2'b01,
    MODE_ALT     = 2'b10
  } pin_mode_t;
endpackage

// ===== hw/shared_pin_function_mux.sv
// shared package pin multiplexer for five pin categories
`timescale 1ns/100ps
`default_nettype none
`include "pin_mux_map.svh"
module shared_pin_function_mux
  import pin_mux_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // category selects, high picks the alternate set
  input  wire logic        video_alt_i,
  input  wire logic        storage_alt_i,
  input  wire logic        nand_alt_i,
  input  wire logic        audio_alt_i,
  input  wire logic        uart_alt_i,
  output logic [4:0]       mode_o,
  // lcd port
  input  wire logic        lcd_port_select_n_i,
  input  wire logic        lcd_port_enable_read_i,
  input  wire logic        lcd_port_register_select_i,
  input  wire logic        lcd_port_read_write_i,
  input  wire logic [15:0] lcd_port_data_i,
  input  wire logic        lcd_port_data_oe_i,
  output logic      [15:0] lcd_port_data_o,
  // external bus unit
  input  wire logic        static_mem_select0_n_i,
  input  wire logic        static_mem_select1_n_i,
  input  wire logic        sdram_clock_out_i,
  input  wire logic        sdram_clock_enable_i,
  input  wire logic        sdram_select_n_i,
  input  wire logic        sdram_byte_mask1_i,
  input  wire logic [15:2] ext_mem_addr_i,
  // general io 5..10
  input  wire logic [5:0]  general_io_i,
  input  wire logic [5:0]  general_io_oe_i,
  output logic      [5:0]  general_io_o,
  // memory card port
  input  wire logic        card_clock_i,
  input  wire logic        card_command_i,
  input  wire logic        card_command_oe_i,
  output logic             card_command_o,
  input  wire logic [7:0]  card_data_i,
  input  wire logic [7:0]  card_data_oe_i,
  output logic      [7:0]  card_data_o,
  // flash ready/busy
  output logic      [3:0]  flash_ready_busy_n_o,
  // audio transmit port 0
  input  wire logic        audio_tx0_serial_data_i,
  input  wire logic        audio_tx0_bit_clock_i,
  input  wire logic        audio_tx0_word_select_i,
  input  wire logic        audio_tx0_master_clock_i,
  // pcm port
  input  wire logic        pcm_line_a_i,
  input  wire logic        pcm_line_a_oe_i,
  input  wire logic        pcm_frame_sync_i,
  input  wire logic        pcm_frame_sync_oe_i,
  input  wire logic        pcm_data_clock_i,
  input  wire logic        pcm_line_b_i,
  input  wire logic        pcm_line_b_oe_i,
  output logic             pcm_line_a_o,
  output logic             pcm_frame_sync_o,
  output logic             pcm_line_b_o,
  // uart modem lines and spi selects
  input  wire logic        uart_rts_n_i,
  output logic             uart_cts_n_o,
  input  wire logic        spi_slave1_select_out_i,
  input  wire logic        spi_slave2_select_out_i,
  // pads
  input  wire logic [19:0] video_pad_i,
  output logic      [19:0] video_pad_o,
  output logic      [19:0] video_pad_oe_o,
  input  wire logic [5:0]  storage_pad_i,
  output logic      [5:0]  storage_pad_o,
  output logic      [5:0]  storage_pad_oe_o,
  input  wire logic [3:0]  nand_pad_i,
  output logic      [3:0]  nand_pad_o,
  output logic      [3:0]  nand_pad_oe_o,
  input  wire logic [3:0]  audio_pad_i,
  output logic      [3:0]  audio_pad_o,
  output logic      [3:0]  audio_pad_oe_o,
  input  wire logic [1:0]  uart_pad_i,
  output logic      [1:0]  uart_pad_o,
  output logic      [1:0]  uart_pad_oe_o
);
  pin_mode_t   video_mode, storage_mode, nand_mode, audio_mode, uart_mode;
  logic [19:0] vid_dflt_out;
  logic [19:0] vid_dflt_oe;
  logic [19:0] vid_alt_out;
  logic [19:0] vid_dflt_in;
  logic [5:0]  sto_alt_out;
  logic [5:0]  sto_alt_oe;
  logic [5:0]  sto_alt_in;
  logic [3:0]  nand_alt_in;
  logic [3:0]  aud_alt_in;
  logic [1:0]  uart_dflt_in;

  function automatic logic is_alt(input pin_mode_t m);
    return m == MODE_ALT;
  endfunction

  function automatic pin_mode_t mode_of(input logic alt);
    return alt ? MODE_ALT : MODE_DEFAULT;
  endfunction

  // category selects, each held on its own so one change never disturbs another
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      video_mode   <= MODE_DEFAULT;
      storage_mode <= MODE_DEFAULT;
      nand_mode    <= MODE_DEFAULT;
      audio_mode   <= MODE_DEFAULT;
      uart_mode    <= MODE_DEFAULT;
      mode_o       <= 5'h00;
    end
    else if (ce_i)
    begin
      video_mode   <= mode_of(video_alt_i);
      storage_mode <= mode_of(storage_alt_i);
      nand_mode    <= mode_of(nand_alt_i);
      audio_mode   <= mode_of(audio_alt_i);
      uart_mode    <= mode_of(uart_alt_i);
      mode_o       <= {uart_alt_i, audio_alt_i, nand_alt_i, storage_alt_i, video_alt_i};
    end
  end

  // lcd owns the video pins by default; data direction follows the lcd
  assign vid_dflt_out = {lcd_port_read_write_i, lcd_port_register_select_i,
                         lcd_port_enable_read_i, lcd_port_select_n_i,
                         lcd_port_data_i};
  assign vid_dflt_oe  = {4'hf, {16{lcd_port_data_oe_i}}};
  // memory unit drives only outputs on these pins
  assign vid_alt_out  = {sdram_byte_mask1_i, sdram_select_n_i, sdram_clock_enable_i,
                         static_mem_select0_n_i, ext_mem_addr_i,
                         static_mem_select1_n_i, sdram_clock_out_i};
  assign lcd_port_data_o = vid_dflt_in[`VID_DB15:`VID_DB0];

  pad_group_mux #(.W(`VID_W), .DFLT_IDLE(`LCD_IDLE), .ALT_IDLE(`MEM_IDLE)) video_mux (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .alt_i      (is_alt(video_mode)),
    .dflt_out_i (vid_dflt_out),
    .dflt_oe_i  (vid_dflt_oe),
    .alt_out_i  (vid_alt_out),
    .alt_oe_i   ({`VID_W{1'b1}}),
    .pad_i      (video_pad_i),
    .pad_o      (video_pad_o),
    .pad_oe_o   (video_pad_oe_o),
    .dflt_in_o  (vid_dflt_in),
    .alt_in_o   ()
  );

  // card clock is output only, command and data lines turn around
  assign sto_alt_out = {card_data_i[3:0], card_command_i, card_clock_i};
  assign sto_alt_oe  = {card_data_oe_i[3:0], card_command_oe_i, 1'b1};
  assign card_command_o = sto_alt_in[`STO_CMD];
  assign card_data_o    = {nand_alt_in, sto_alt_in[`STO_DAT3:`STO_DAT0]};

  pad_group_mux #(.W(`STO_W), .DFLT_IDLE(`GPIO_IDLE), .ALT_IDLE(`CARD_IDLE)) storage_mux (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .alt_i      (is_alt(storage_mode)),
    .dflt_out_i (general_io_i),
    .dflt_oe_i  (general_io_oe_i),
    .alt_out_i  (sto_alt_out),
    .alt_oe_i   (sto_alt_oe),
    .pad_i      (storage_pad_i),
    .pad_o      (storage_pad_o),
    .pad_oe_o   (storage_pad_oe_o),
    .dflt_in_o  (general_io_o),
    .alt_in_o   (sto_alt_in)
  );

  // ready/busy pins are inputs only, so the default owner never drives
  pad_group_mux #(.W(`NAND_W), .DFLT_IDLE(`RB_IDLE), .ALT_IDLE(`CARD_HI_IDLE)) nand_mux (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .alt_i      (is_alt(nand_mode)),
    .dflt_out_i (4'h0),
    .dflt_oe_i  (4'h0),
    .alt_out_i  (card_data_i[7:4]),
    .alt_oe_i   (card_data_oe_i[7:4]),
    .pad_i      (nand_pad_i),
    .pad_o      (nand_pad_o),
    .pad_oe_o   (nand_pad_oe_o),
    .dflt_in_o  (flash_ready_busy_n_o),
    .alt_in_o   (nand_alt_in)
  );

  // pcm frame sync may be an input when the pcm port is a slave
  assign pcm_line_a_o     = aud_alt_in[`AUD_LINE_A];
  assign pcm_frame_sync_o = aud_alt_in[`AUD_SYNC];
  assign pcm_line_b_o     = aud_alt_in[`AUD_LINE_B];

  pad_group_mux #(.W(`AUD_W), .DFLT_IDLE(`I2S_IDLE), .ALT_IDLE(`PCM_IDLE)) audio_mux (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .alt_i      (is_alt(audio_mode)),
    .dflt_out_i ({audio_tx0_master_clock_i, audio_tx0_word_select_i,
                  audio_tx0_bit_clock_i, audio_tx0_serial_data_i}),
    .dflt_oe_i  (4'hf),
    .alt_out_i  ({pcm_line_b_i, pcm_data_clock_i, pcm_frame_sync_i, pcm_line_a_i}),
    .alt_oe_i   ({pcm_line_b_oe_i, 1'b1, pcm_frame_sync_oe_i, pcm_line_a_oe_i}),
    .pad_i      (audio_pad_i),
    .pad_o      (audio_pad_o),
    .pad_oe_o   (audio_pad_oe_o),
    .dflt_in_o  (),
    .alt_in_o   (aud_alt_in)
  );

  // cts is an input, rts an output; both spi selects are outputs
  assign uart_cts_n_o = uart_dflt_in[`UART_CTS];

  pad_group_mux #(.W(`UART_W), .DFLT_IDLE(`MODEM_IDLE), .ALT_IDLE(`SPI_IDLE)) uart_mux (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .alt_i      (is_alt(uart_mode)),
    .dflt_out_i ({uart_rts_n_i, 1'b0}),
    .dflt_oe_i  (2'b10),
    .alt_out_i  ({spi_slave2_select_out_i, spi_slave1_select_out_i}),
    .alt_oe_i   (2'b11),
    .pad_i      (uart_pad_i),
    .pad_o      (uart_pad_o),
    .pad_oe_o   (uart_pad_oe_o),
    .dflt_in_o  (uart_dflt_in),
    .alt_in_o   ()
  );

  // checks: pads follow their owner one enabled edge later
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence vid_alt_s;
    ce_i && is_alt(video_mode);
  endsequence
  sequence vid_dflt_s;
    ce_i && !is_alt(video_mode);
  endsequence

  lcd_default_drive_a: assert property (vid_dflt_s |=> video_pad_o == $past(vid_dflt_out)
    && video_pad_oe_o[`VID_CS] && video_pad_oe_o[`VID_RW])
    else $error("lcd signals not on video pins");
  static_selects_a: assert property (vid_alt_s |=>
    video_pad_o[`VID_CS] == $past(static_mem_select0_n_i)
    && video_pad_o[`VID_DB1] == $past(static_mem_select1_n_i))
    else $error("static selects misrouted");
  sdram_control_a: assert property (vid_alt_s |=>
    video_pad_o[`VID_DB0] == $past(sdram_clock_out_i)
    && video_pad_o[`VID_ERD] == $past(sdram_clock_enable_i)
    && video_pad_o[`VID_RS] == $past(sdram_select_n_i)
    && video_pad_o[`VID_RW] == $past(sdram_byte_mask1_i))
    else $error("sdram control misrouted");
  mem_address_a: assert property (vid_alt_s |=>
    video_pad_o[`VID_DB15:`VID_DB2] == $past(ext_mem_addr_i)
    && video_pad_oe_o == {`VID_W{1'b1}})
    else $error("address lines misrouted");
  card_storage_a: assert property (ce_i && is_alt(storage_mode) |=>
    storage_pad_o == $past(sto_alt_out) && storage_pad_oe_o[`STO_CLK])
    else $error("card lines not on storage pins");
  card_upper_a: assert property (ce_i && is_alt(nand_mode) |=>
    nand_pad_o == $past(card_data_i[7:4]) && flash_ready_busy_n_o == `RB_IDLE)
    else $error("card data 4-7 misrouted");
  pcm_audio_a: assert property (ce_i && is_alt(audio_mode) |=>
    audio_pad_o[`AUD_DCLK] == $past(pcm_data_clock_i) && audio_pad_oe_o[`AUD_DCLK]
    && audio_pad_o[`AUD_LINE_A] == $past(pcm_line_a_i))
    else $error("pcm signals misrouted");
  spi_select_a: assert property (ce_i && is_alt(uart_mode) |=>
    uart_pad_o == $past({spi_slave2_select_out_i, spi_slave1_select_out_i})
    && uart_pad_oe_o == 2'b11 && uart_cts_n_o)
    else $error("spi selects misrouted");
  select_follow_a: assert property (ce_i |=> is_alt(nand_mode) == $past(nand_alt_i)
    && is_alt(video_mode) == $past(video_alt_i) && mode_o[2] == $past(nand_alt_i))
    else $error("category select did not follow");
  idle_inputs_a: assert property (ce_i && !is_alt(storage_mode) ##1 ce_i
    && !is_alt(storage_mode) |=> card_command_o && card_data_o[3:0] == 4'hf)
    else $error("unrouted card port not idle");
endmodule
`default_nettype wire
